//--- core/acpc_consts.svh
// Timing and field constants for the calibration and power control block
`ifndef ACPC_CONSTS_SVH
`define ACPC_CONSTS_SVH
// ==========================================================
// Qualification and delay defaults, in input clock cycles
`define ACPC_CAL_LOW_CYC 32'h0000_0050
`define ACPC_CAL_HIGH_CYC 32'h0000_0050
`define ACPC_DLY_SHORT_CYC 32'h0000_1000
`define ACPC_DLY_LONG_CYC 32'h0001_0000
// Calibration run lengths, in cycles
`define ACPC_CAL_FULL_CYC 32'h0000_0800
`define ACPC_CAL_TRIM_CYC 32'h0000_0400
// Full-scale code and counter widths and values
`define ACPC_FS_W 8
`define ACPC_FS_NORMAL 8'hFF
`define ACPC_FS_REDUCED 8'hBF
`define ACPC_CNT_W 32
`define ACPC_ZERO_CNT 32'h0000_0000
`define ACPC_ONE_CNT 32'h0000_0001
`endif

//--- core/acpc_counter.sv
// Saturating run-length counter with clear and hold
`timescale 1ns/1ps
`include "acpc_consts.svh"
module acpc_counter #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic clear,
   input wire logic enable,
   // Count
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   // Saturation keeps a long level from wrapping back to a short count
   assign count_nxt = clear ? '0 :
                      (enable && (count_r != {WIDTH{1'b1}})) ? count_r + 1'b1 : count_r;
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end
   assign count = count_r;
endmodule // acpc_counter

//--- core/acpc_ctrl.sv
// Calibration sequencing and power-down control of the converter
// Notes on behaviour
// - cal_active is high exactly while a calibration runs.
// - Power-up calibration starts only after the selected power-up delay.
// - cal_delay_select picks the short or the long power-up delay.
// - Request high at power-up skips the automatic calibration.
// - Calibration starts high-hold cycles after a qualified rise; short pulses ignored.
// - Same sequence whether the clock runs at power-up or later.
// - Analog section held down while power-up logic waits for clock.
// - Power-up calibration includes termination trim; on-command only re-trims.
// - Power-down high at power-up halts the delay counter.
// - Extended mode disables the delay select pin.
// - Range from full-scale pin normally, from register in extended mode.
// - Edge select high: data changes on rising data clock edge.
// - Level select picks strong drive when high, low drive when low.
// - Power-down suspends operation and floats data outputs.
// - Power-down during calibration waits for calibration to finish.
// - Requests during power-down are ignored entirely.
// - Extended mode takes range and offset from control registers.
`timescale 1ns/1ps
`include "acpc_consts.svh"
module acpc_ctrl
   import acpc_pkg::*;
#(
   parameter acpc_pkg::acpc_cnt_t CAL_LOW_CYC = `ACPC_CAL_LOW_CYC,
   parameter acpc_pkg::acpc_cnt_t CAL_HIGH_CYC = `ACPC_CAL_HIGH_CYC,
   parameter acpc_pkg::acpc_cnt_t DLY_SHORT_CYC = `ACPC_DLY_SHORT_CYC,
   parameter acpc_pkg::acpc_cnt_t DLY_LONG_CYC = `ACPC_DLY_LONG_CYC,
   parameter acpc_pkg::acpc_cnt_t CAL_FULL_CYC = `ACPC_CAL_FULL_CYC,
   parameter acpc_pkg::acpc_cnt_t CAL_TRIM_CYC = `ACPC_CAL_TRIM_CYC
) (
   // Clock and reset; reset stands for power application
   input wire logic clk,
   input wire logic rst_n,
   // Control pins from the host, asynchronous
   input wire logic cal_request_in,
   input wire logic power_down_in,
   input wire logic cal_delay_select,
   input wire logic full_scale_select,
   input wire logic output_edge_select,
   input wire logic output_level_select,
   // Extended control mode and its register settings
   input wire logic extended_mode,
   input wire logic [`ACPC_FS_W-1:0] ext_full_scale,
   input wire logic [`ACPC_FS_W-1:0] ext_offset,
   // Status
   output logic cal_active,
   output logic cal_term_trim,
   output logic analog_power_down,
   output logic data_out_en,
   // Data path settings
   output logic [`ACPC_FS_W-1:0] full_scale_code,
   output logic [`ACPC_FS_W-1:0] offset_code,
   output logic data_on_rising,
   output logic drive_strong
);
   import acpc_pkg::*;

   // ==========================================================
   // State decoding shared by the sequencer and the output registers
   function automatic logic is_cal(input acpc_state_e st);
      return (st == ACPC_ST_CAL_FULL) || (st == ACPC_ST_CAL_TRIM);
   endfunction
   // Power-down acts in its own state and, at power-up, while it halts the delay
   function automatic logic is_held_down(input acpc_state_e st, input logic down);
      return (st == ACPC_ST_POWER_DOWN) || ((st == ACPC_ST_WAIT_DELAY) && down);
   endfunction

   // ==========================================================
   // Synchronised inputs
   logic [1:0] pins_sync;
   logic req_s;
   logic down_s;
   logic req_d_r;
   logic [1:0] strap_r;
   logic strap_taken_r;
   logic req_strap_r;

   acpc_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({power_down_in, cal_request_in}),
      .sync_out(pins_sync)
   );
   assign req_s = pins_sync[0];
   assign down_s = pins_sync[1];

   // ==========================================================
   // Request qualification
   acpc_cnt_t low_cnt;
   acpc_cnt_t high_cnt;
   acpc_cnt_t seq_cnt;
   logic armed_r;
   logic armed_nxt;
   logic req_rise;
   logic req_fire;
   logic low_ok;

   acpc_counter #(
      .WIDTH(`ACPC_CNT_W)
   ) u_low_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .clear(req_s),
      .enable(!req_s),
      .count(low_cnt)
   );

   acpc_counter #(
      .WIDTH(`ACPC_CNT_W)
   ) u_high_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .clear(!req_s),
      .enable(req_s),
      .count(high_cnt)
   );

   assign req_rise = req_s && !req_d_r;
   assign low_ok = (low_cnt >= CAL_LOW_CYC);

   // State
   acpc_state_e state_r;
   acpc_state_e state_nxt;
   logic seq_clear;
   logic dly_done;
   logic dly_run;
   logic cal_done;
   logic down_state;
   acpc_cnt_t dly_target;

   // arming is cleared in power-down, so old requests die
   // arm on a rise after a long enough low; drop arm if pulse ends early
   assign armed_nxt = down_state ? 1'b0 :
                      (req_rise && low_ok) ? 1'b1 :
                      (!req_s) ? 1'b0 :
                      req_fire ? 1'b0 : armed_r;
   assign req_fire = armed_r && req_s && (high_cnt >= CAL_HIGH_CYC) && !down_state;

   // ==========================================================
   // Delay and calibration run counter
   // delay counter stops while power-down is high
   // Holding it in the power-down state too costs nothing: every run starts cleared
   assign dly_run = !is_held_down(state_r, down_s);
   acpc_counter #(
      .WIDTH(`ACPC_CNT_W)
   ) u_seq_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .clear(seq_clear),
      .enable(dly_run),
      .count(seq_cnt)
   );

   // two delay choices; extended mode forces the short one
   assign dly_target = (cal_delay_select && !extended_mode) ? DLY_LONG_CYC : DLY_SHORT_CYC;
   assign dly_done = (seq_cnt >= dly_target) && !down_s;
   // power-up run is longer as it also trims termination
   assign cal_done = (state_r == ACPC_ST_CAL_FULL) ? (seq_cnt >= CAL_FULL_CYC - `ACPC_ONE_CNT) :
                     (seq_cnt >= CAL_TRIM_CYC - `ACPC_ONE_CNT);
   assign down_state = (state_r == ACPC_ST_POWER_DOWN);

   // ==========================================================
   // Next state; all timing is counted on clk, so a late clock only delays it
   always_comb begin
      state_nxt = state_r;
      seq_clear = 1'b0;
      unique case (state_r)
         ACPC_ST_WAIT_DELAY: begin
            // request strap high at power-up skips auto calibration
            if (strap_taken_r && req_strap_r) begin
               state_nxt = ACPC_ST_IDLE;
               seq_clear = 1'b1;
            end else if (strap_taken_r && dly_done) begin
               state_nxt = ACPC_ST_CAL_FULL;
               seq_clear = 1'b1;
            end
         end
         ACPC_ST_CAL_FULL, ACPC_ST_CAL_TRIM: begin
            // power-down only looked at once calibration ends
            if (cal_done) begin
               state_nxt = down_s ? ACPC_ST_POWER_DOWN : ACPC_ST_IDLE;
               seq_clear = 1'b1;
            end
         end
         ACPC_ST_IDLE: begin
            if (down_s) begin
               state_nxt = ACPC_ST_POWER_DOWN;
            end else if (req_fire) begin
               state_nxt = ACPC_ST_CAL_TRIM;
               seq_clear = 1'b1;
            end
         end
         ACPC_ST_POWER_DOWN: begin
            if (!down_s) begin
               state_nxt = ACPC_ST_IDLE;
            end
         end
         // Unused codes of the state word restart the power-up sequence
         default: begin
            state_nxt = ACPC_ST_WAIT_DELAY;
         end
      endcase
   end

   // ==========================================================
   // Sequencer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ACPC_ST_WAIT_DELAY;
         armed_r <= 1'b0;
         req_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         armed_r <= armed_nxt;
         req_d_r <= req_s;
      end
   end

   // ==========================================================
   // Strap capture, one cycle after the synchroniser has filled; any earlier
   // and the request level would still read as the synchroniser's reset value
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap_r <= 2'b00;
         strap_taken_r <= 1'b0;
         req_strap_r <= 1'b0;
      end else begin
         strap_r <= {strap_r[0], 1'b1};
         if (strap_r[1] && !strap_taken_r) begin
            strap_taken_r <= 1'b1;
            req_strap_r <= req_s;
         end
      end
   end

   // ==========================================================
   // Outputs from flip-flops
   logic cal_active_r;
   logic term_r;
   logic apd_r;
   logic oen_r;
   logic [`ACPC_FS_W-1:0] fs_r;
   logic [`ACPC_FS_W-1:0] off_r;
   logic edge_r;
   logic drive_r;
   logic cal_nxt;
   logic term_nxt;
   logic hold_nxt;
   logic apd_nxt;
   logic oen_nxt;
   logic [`ACPC_FS_W-1:0] fs_nxt;
   logic [`ACPC_FS_W-1:0] off_nxt;

   assign cal_nxt = is_cal(state_nxt);
   // termination trim only during the power-up run
   assign term_nxt = (state_nxt == ACPC_ST_CAL_FULL);
   // minimum power in power-down, and while it halts the power-up delay
   // never true in a calibration state, so a running calibration keeps power
   assign hold_nxt = is_held_down(state_nxt, down_s);
   // analog held down until the delay phase has seen the clock run
   assign apd_nxt = hold_nxt || !strap_taken_r;
   // Outputs float until the strap is taken, so nothing stale leaves at power-up
   assign oen_nxt = !hold_nxt && strap_taken_r;
   // range from pin or from the extended register
   assign fs_nxt = extended_mode ? ext_full_scale :
                   (full_scale_select ? `ACPC_FS_NORMAL : `ACPC_FS_REDUCED);
   // offset only set in extended mode
   assign off_nxt = extended_mode ? ext_offset : '0;

   // ==========================================================
   // Calibration status; both flags leave the state decode in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cal_active_r <= 1'b0;
         term_r <= 1'b0;
      end else begin
         cal_active_r <= cal_nxt;
         term_r <= term_nxt;
      end
   end

   // ==========================================================
   // Power state; reset leaves the analog section down and the outputs floating
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         apd_r <= 1'b1;
         oen_r <= 1'b0;
      end else begin
         apd_r <= apd_nxt;
         oen_r <= oen_nxt;
      end
   end

   // ==========================================================
   // Range and offset; a change of pin or register reaches the core one cycle later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fs_r <= `ACPC_FS_NORMAL;
         off_r <= '0;
      end else begin
         fs_r <= fs_nxt;
         off_r <= off_nxt;
      end
   end

   // ==========================================================
   // Output edge and drive level; static pins, sampled only to register them
   // They are not synchronised: a change mid-run may glitch one output word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edge_r <= 1'b1;
         drive_r <= 1'b1;
      end else begin
         edge_r <= output_edge_select;
         drive_r <= output_level_select;
      end
   end

   // ==========================================================
   // Port assignments
   assign cal_active = cal_active_r;
   assign cal_term_trim = term_r;
   assign analog_power_down = apd_r;
   assign data_out_en = oen_r;
   assign full_scale_code = fs_r;
   assign offset_code = off_r;
   assign data_on_rising = edge_r;
   assign drive_strong = drive_r;
endmodule // acpc_ctrl

//--- core/acpc_pkg.sv
// Types shared by the calibration and power control block
package acpc_pkg;
   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ACPC_ST_WAIT_DELAY,
      ACPC_ST_CAL_FULL,
      ACPC_ST_IDLE,
      ACPC_ST_CAL_TRIM,
      ACPC_ST_POWER_DOWN
   } acpc_state_e;
   typedef logic [31:0] acpc_cnt_t;
endpackage

//--- core/acpc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`include "acpc_consts.svh"
module acpc_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   // ==========================================================
   // Only the second stage is visible outside
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end
   assign sync_out = sync_r;
endmodule // acpc_sync

//--- tb/acpc_ctrl_assertions.sv
// Port checker of the calibration and power control block
`timescale 1ns/1ps
`include "acpc_consts.svh"
module acpc_ctrl_chk
   import acpc_pkg::*;
#(
   parameter acpc_pkg::acpc_cnt_t CAL_HIGH_CYC = `ACPC_CAL_HIGH_CYC,
   parameter acpc_pkg::acpc_cnt_t DLY_SHORT_CYC = `ACPC_DLY_SHORT_CYC,
   parameter acpc_pkg::acpc_cnt_t DLY_LONG_CYC = `ACPC_DLY_LONG_CYC,
   parameter acpc_pkg::acpc_cnt_t CAL_FULL_CYC = `ACPC_CAL_FULL_CYC,
   parameter acpc_pkg::acpc_cnt_t CAL_TRIM_CYC = `ACPC_CAL_TRIM_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic cal_request_in,
   input wire logic power_down_in,
   input wire logic cal_delay_select,
   input wire logic full_scale_select,
   input wire logic output_edge_select,
   input wire logic output_level_select,
   input wire logic extended_mode,
   input wire logic [`ACPC_FS_W-1:0] ext_full_scale,
   input wire logic [`ACPC_FS_W-1:0] ext_offset,
   // Outputs
   input wire logic cal_active,
   input wire logic cal_term_trim,
   input wire logic analog_power_down,
   input wire logic data_out_en,
   input wire logic [`ACPC_FS_W-1:0] full_scale_code,
   input wire logic [`ACPC_FS_W-1:0] offset_code,
   input wire logic data_on_rising,
   input wire logic drive_strong
);
   acpc_cnt_t run_r;
   acpc_cnt_t up_r;
   // ====================
   // Run length and cycles since power-up, so lengths need no long repetition
   always_ff @(posedge clk) begin
      run_r <= (rst_n && cal_active) ? run_r + 1 : '0;
      up_r <= rst_n ? up_r + 1 : '0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ====================
   // Calibration
   a_cal_run_len: assert property (
      $fell(cal_active) |-> run_r == ($past(cal_term_trim) ? CAL_FULL_CYC : CAL_TRIM_CYC))
      else $error("calibration length wrong");
   a_pup_delay: assert property (
      $rose(cal_active) && cal_term_trim |->
         up_r >= ((cal_delay_select && !extended_mode) ? DLY_LONG_CYC : DLY_SHORT_CYC))
      else $error("power-up calibration early");
   a_cmd_hold: assert property (
      $rose(cal_active) && !cal_term_trim |->
         $past(cal_request_in, CAL_HIGH_CYC) && $past(cal_request_in, 3))
      else $error("command calibration without held request");
   a_trim_in_cal: assert property (cal_term_trim |-> cal_active)
      else $error("trim flag outside calibration");
   a_cal_powered: assert property (cal_active |-> !analog_power_down)
      else $error("powered down during calibration");
   a_pd_enters: assert property (
      (power_down_in && !cal_active)[*5] |-> analog_power_down && !data_out_en)
      else $error("power-down not applied");
   // ====================
   // Static selects, one cycle behind the pins
   a_fs_code: assert property (
      $past(rst_n) |-> full_scale_code == ($past(extended_mode) ? $past(ext_full_scale)
         : ($past(full_scale_select) ? `ACPC_FS_NORMAL : `ACPC_FS_REDUCED)))
      else $error("full-scale code wrong");
   a_offset_code: assert property (
      $past(rst_n) |-> offset_code == ($past(extended_mode) ? $past(ext_offset) : 8'h00))
      else $error("offset code wrong");
   a_out_select: assert property (
      $past(rst_n) |-> data_on_rising == $past(output_edge_select)
         && drive_strong == $past(output_level_select))
      else $error("output selects wrong");
   c_pup_cal: cover property ($rose(cal_active) && cal_term_trim);
   c_cmd_cal: cover property ($rose(cal_active) && !cal_term_trim);
   c_pd_entry: cover property ($rose(analog_power_down));
endmodule // acpc_ctrl_chk
bind acpc_ctrl acpc_ctrl_chk #(.CAL_HIGH_CYC(CAL_HIGH_CYC), .DLY_SHORT_CYC(DLY_SHORT_CYC),
   .DLY_LONG_CYC(DLY_LONG_CYC), .CAL_FULL_CYC(CAL_FULL_CYC), .CAL_TRIM_CYC(CAL_TRIM_CYC))
   u_chk (.clk, .rst_n, .cal_request_in, .power_down_in, .cal_delay_select,
   .full_scale_select, .output_edge_select, .output_level_select, .extended_mode,
   .ext_full_scale, .ext_offset, .cal_active, .cal_term_trim, .analog_power_down,
   .data_out_en, .full_scale_code, .offset_code, .data_on_rising, .drive_strong);

//--- tb/acpc_host.sv
// Host model driving the calibration request pin
`timescale 1ns/1ps
module acpc_host (
   // Clock
   input wire logic clk,
   // Pins
   input wire logic cal_active,
   input wire logic data_out_en,
   output logic cal_request_in
);
   initial cal_request_in = 1'b0;
   // Level change at the falling edge
   task automatic level(input logic v);
      @(negedge clk);
      cal_request_in = v;
   endtask
   // low hold, then high; pin is left high
   task automatic request(input int lo, input int hi);
      level(1'b0);
      repeat (lo) @(negedge clk);
      cal_request_in = 1'b1;
      repeat (hi) @(negedge clk);
   endtask
   // words after power-down are garbage until the pipeline has flushed
   task automatic flush(input int cyc);
      wait (data_out_en === 1'b1);
      repeat (cyc) @(negedge clk);
   endtask
   // done once cal_active is low again, or after lim-1 cycles
   task automatic wait_done(input int lim, output int cnt);
      for (cnt = 1; cnt < lim; cnt++) begin
         @(negedge clk);
         if (cal_active === 1'b0) break;
      end
   endtask
endmodule // acpc_host

//--- tb/adc_calibration_power_control_test.sv
// Self-checking bench for the calibration and power control block
`timescale 1ns/1ps
`include "acpc_consts.svh"
module adc_calibration_power_control_test;
   import acpc_pkg::*;
   // Short counts keep the run brief
   localparam int LO = 4, HI = 4, DS = 16, DL = 32, CF = 8, CT = 4;
   logic clk = 0, rst_n = 0, power_down_in = 0, cal_delay_select = 0, extended_mode = 0;
   logic full_scale_select = 1, output_edge_select = 1, output_level_select = 1;
   logic [7:0] ext_full_scale = 0, ext_offset = 0, full_scale_code, offset_code;
   logic cal_request_in, cal_active, cal_term_trim, analog_power_down, data_out_en;
   logic data_on_rising, drive_strong;
   int mismatches = 0, checked = 0, cyc = 0, n, e;
   always #2 clk = ~clk;
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   acpc_ctrl #(.CAL_LOW_CYC(LO), .CAL_HIGH_CYC(HI), .DLY_SHORT_CYC(DS), .DLY_LONG_CYC(DL),
      .CAL_FULL_CYC(CF), .CAL_TRIM_CYC(CT)) DUT (.clk, .rst_n, .cal_request_in,
      .power_down_in, .cal_delay_select, .full_scale_select, .output_edge_select,
      .output_level_select, .extended_mode, .ext_full_scale, .ext_offset, .cal_active,
      .cal_term_trim, .analog_power_down, .data_out_en, .full_scale_code, .offset_code,
      .data_on_rising, .drive_strong);
   acpc_host HOST (.clk, .cal_active, .data_out_en, .cal_request_in);
   // ====================
   // Helpers
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic int exp_dly(logic sel, logic ext);
      return (sel && !ext) ? DL : DS;
   endfunction
   function automatic logic [7:0] exp_fs(logic ext, logic fss, logic [7:0] efs);
      return ext ? efs : (fss ? `ACPC_FS_NORMAL : `ACPC_FS_REDUCED);
   endfunction
   // Power application: straps set, reset held 11 cycles
   task automatic power_up(input logic sel, input logic ext, input logic req, input logic pd);
      rst_n = 0;
      cal_delay_select = sel;
      extended_mode = ext;
      power_down_in = pd;
      HOST.level(req);
      repeat (10) @(negedge clk);
      rst_n = 1;
   endtask
   task automatic wait_cal(input int lim, output int cnt);
      for (cnt = 0; cnt < lim && cal_active !== 1'b1; cnt++) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ====================
   // Scenarios
   initial begin
      void'($urandom(32'h2aac));
      for (int s = 0; s < 3; s++) begin
         power_up(s >= 1, s == 2, 0, 0);
         e = exp_dly(s >= 1, s == 2);
         wait_cal(DL + 20, n);
         check("pup delay", 1, n >= e && n <= e + 8);
         check("term trim", 1, cal_term_trim);
         HOST.wait_done(20, n);
         check("full cal len", CF, n);
      end
      // Strapped request, then a short low and a short high
      power_up(0, 0, 1, 0);
      wait_cal(DL + 20, n);
      check("strap skip", DL + 20, n);
      HOST.request(1, 20);
      wait_cal(30, n);
      check("short low", 30, n);
      HOST.request(LO + 2, HI - 2);
      HOST.level(0);
      wait_cal(30, n);
      check("short high", 30, n);
      HOST.request(LO + 2, 1);
      wait_cal(HI + 12, n);
      check("cmd cal", 1, cal_active && !cal_term_trim);
      HOST.wait_done(20, n);
      check("trim cal len", CT, n);
      // Random static selects with a reduced-range corner
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         {extended_mode, full_scale_select, output_edge_select, output_level_select,
            ext_full_scale, ext_offset} = 20'($urandom);
         if (i == 0) {extended_mode, full_scale_select} = 2'b00;
         @(negedge clk);
         e = exp_fs(extended_mode, full_scale_select, ext_full_scale);
         check("fs code", e, full_scale_code);
         check("offset", extended_mode ? ext_offset : 8'h00, offset_code);
         check("edge", output_edge_select, data_on_rising);
         check("drive", output_level_select, drive_strong);
      end
      extended_mode = 0;
      // Power-down raised mid-run, then a request while down
      HOST.request(LO + 2, 1);
      wait_cal(HI + 12, n);
      power_down_in = 1;
      HOST.wait_done(20, n);
      check("cal len in pd", CT, n);
      repeat (5) @(negedge clk);
      check("data hi-z", 0, data_out_en);
      check("analog off", 1, analog_power_down);
      HOST.request(LO + 2, HI + 8);
      power_down_in = 0;
      wait_cal(40, n);
      check("pd request", 40, n);
      check("data on", 1, data_out_en);
      HOST.flush(8);
      // Power-down held at power-up stalls the delay
      power_up(0, 0, 0, 1);
      wait_cal(DL + 10, n);
      check("pd holds delay", DL + 10, n);
      check("pd hold hi-z", 0, data_out_en);
      check("pd hold analog", 1, analog_power_down);
      power_down_in = 0;
      wait_cal(DS + 12, n);
      check("delay after pd", 1, n >= DS && cal_term_trim);
      complete_run();
   end
endmodule // adc_calibration_power_control_test
